/* File: common/utic_regs.vh */
`ifndef UTIC_REGS_VH
`define UTIC_REGS_VH
// Byte addresses of the AXI4-Lite register words. The status/control word
// keeps its printed index; its byte address is four times that index.
`define UTIC_ADDR_STATUS_CTRL 10'h2e8
`define UTIC_ADDR_IRQ_STATUS  10'h0c0
`define UTIC_ADDR_IRQ_MASK    10'h0c4
`define UTIC_ADDR_TX_DATA     10'h0c8
`define UTIC_ADDR_FAULTS      10'h0cc
// Index of the serial status/control register as printed.
`define UTIC_IDX_STATUS_CTRL  8'hba
// Field positions of the serial status/control register.
`define UTIC_BIT_DBUF_MODE    7
`define UTIC_BIT_LATE         6
`define UTIC_BIT_SPLIT        5
`define UTIC_BIT_DBUF_IRQ     4
`define UTIC_BIT_FRAMING      3
`define UTIC_BIT_HOLD_LOW     2
`define UTIC_BIT_OVERRUN      1
`define UTIC_BIT_STAT_EN      0
`define UTIC_RESET_STATUS     8'h00
// Sticky event bits in the interrupt status word.
`define UTIC_EV_TX            0
`define UTIC_EV_RX            1
`define UTIC_EV_FAULT         2
`define UTIC_EV_COUNT         3
// AXI response codes.
`define UTIC_RESP_OKAY        2'b00
`define UTIC_RESP_SLVERR      2'b10
`endif

/* File: verilog/utic_tx_sched.v */
`timescale 1ns/1ps
`default_nettype none
`include "utic_regs.vh"
module utic_tx_sched (
  input  wire aclk,        // System clock.
  input  wire aresetn,     // Synchronous reset, active low.
  input  wire dbuf_mode,   // Double buffering on.
  input  wire dbuf_irq,    // Extra-interrupt select.
  input  wire late,        // Interrupt at end of stop bit.
  input  wire wr_char,     // Character written to the buffer.
  input  wire stop_start,  // Engine: stop bit begins.
  input  wire stop_end,    // Engine: stop bit ends.
  input  wire buf_empty,   // Engine: no character pending.
  output reg  tx_event     // One-cycle transmit interrupt event.
);
  wire stop_pt = late ? stop_end : stop_start;
  wire next_tx_event = (dbuf_mode && dbuf_irq) ?
                       (wr_char || (stop_pt && buf_empty)) :
                       stop_pt;

  always @(posedge aclk) begin
    if (!aresetn)
      tx_event <= 1'b0;
    else
      tx_event <= next_tx_event;
  end
endmodule
`default_nettype wire

/* File: verilog/utic_top.v */
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "utic_regs.vh"
module utic_top (
  input  wire        aclk,           // System clock, 10 MHz.
  input  wire        aresetn,        // Synchronous reset, active low.
  input  wire [9:0]  s_axi_awaddr,   // Write address.
  input  wire        s_axi_awvalid,  // Write address valid.
  output wire        s_axi_awready,  // Write address ready.
  input  wire [31:0] s_axi_wdata,    // Write data.
  input  wire [3:0]  s_axi_wstrb,    // Write strobes.
  input  wire        s_axi_wvalid,   // Write data valid.
  output wire        s_axi_wready,   // Write data ready.
  output reg  [1:0]  s_axi_bresp,    // Write response.
  output reg         s_axi_bvalid,   // Write response valid.
  input  wire        s_axi_bready,   // Write response ready.
  input  wire [9:0]  s_axi_araddr,   // Read address.
  input  wire        s_axi_arvalid,  // Read address valid.
  output wire        s_axi_arready,  // Read address ready.
  output reg  [31:0] s_axi_rdata,    // Read data.
  output reg  [1:0]  s_axi_rresp,    // Read response.
  output reg         s_axi_rvalid,   // Read valid.
  input  wire        s_axi_rready,   // Read ready.
  input  wire        stop_start,     // Engine pulse: stop bit begins.
  input  wire        stop_end,       // Engine pulse: stop bit ends.
  input  wire        mode0_end,      // Engine pulse: eighth bit ends in mode 0.
  input  wire        mode0,          // Engine is in shift-register mode 0.
  input  wire        buf_empty,      // Engine: no character pending.
  input  wire        rx_done_set,    // Engine pulse: character received.
  input  wire        framing_set,    // Engine pulse: framing fault.
  input  wire        hold_low_set,   // Engine pulse: line held low.
  input  wire        overrun_set,    // Engine pulse: overrun.
  output reg  [7:0]  tx_char,        // Character written to the serial buffer.
  output reg         tx_char_load,   // One-cycle strobe with tx_char.
  output wire        tx_double_buffer_mode, // Double buffer on.
  output wire        tx_irq_late_select,    // Late interrupt placement.
  output reg         tx_done_flag,   // Transmit done flag.
  output reg         rx_done_flag,   // Receive done flag.
  output wire        serial_irq,     // Combined or receive/status request.
  output wire        tx_irq,         // Separate transmit request.
  output wire        irq             // Masked sticky-event interrupt.
);
  reg [7:0] serial_port_status_control;
  reg [`UTIC_EV_COUNT-1:0] irq_status;
  reg [`UTIC_EV_COUNT-1:0] irq_mask;
  // Halves of a write that are held until their partner arrives.
  reg       aw_hold;
  reg [9:0] aw_addr;
  reg       w_hold;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire      tx_event;

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data may arrive in either order.
  assign s_axi_awready = !aw_hold && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold && !s_axi_bvalid;
  // The write executes once both halves are held and no answer is pending.
  wire do_write = aw_hold && w_hold && !s_axi_bvalid;

  // Every write is gated by the low byte lane strobe, even the done-flag clears
  // in bits 9/8; a write without it is answered but changes nothing. An
  // unmapped address gets a slave error and leaves every register untouched.
  wire hit_ctrl = aw_addr == `UTIC_ADDR_STATUS_CTRL;
  wire hit_mask = aw_addr == `UTIC_ADDR_IRQ_MASK;
  wire hit_tx   = aw_addr == `UTIC_ADDR_TX_DATA;
  wire hit_flt  = aw_addr == `UTIC_ADDR_FAULTS;
  wire wr_ok    = hit_ctrl || hit_mask || hit_tx || hit_flt;
  wire wr_ctrl  = do_write && hit_ctrl && w_strb[0];
  wire wr_mask  = do_write && hit_mask && w_strb[0];
  wire wr_tx    = do_write && hit_tx && w_strb[0];
  wire wr_flt   = do_write && hit_flt && w_strb[0];

  // Address half of a write. It is held until the write executes so that the
  // data half may arrive earlier, later or in the same cycle.
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      aw_addr <= 10'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_hold <= 1'b0;
    end
  end

  // Data half of a write.
  always @(posedge aclk) begin
    if (!aresetn) begin
      w_hold <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_hold <= 1'b0;
    end
  end

  // Response. Both ready outputs stay low while it waits, so a second write
  // cannot overtake the answer to the first.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `UTIC_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? `UTIC_RESP_OKAY : `UTIC_RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status/control register. Hardware sets of the fault flags win over a
  // software clear in the same cycle so no event is lost.
  wire [7:0] flt_set = {4'h0, framing_set, hold_low_set, overrun_set, 1'b0};
  // Writable control fields: double buffer, late, split, buffer select and
  // status enable. Fault flags take a zero to clear and a one to keep.
  wire [7:0] ctrl_wmask = 8'hf1;
  reg  [7:0] next_status_ctrl;

  always @* begin
    next_status_ctrl = serial_port_status_control | flt_set;
    if (wr_ctrl) begin
      next_status_ctrl = (w_data[7:0] & ctrl_wmask) |
                         (serial_port_status_control & w_data[7:0] & ~ctrl_wmask) |
                         flt_set;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      serial_port_status_control <= `UTIC_RESET_STATUS;
    end else begin
      serial_port_status_control <= next_status_ctrl;
    end
  end

  // The engine reads its double-buffer and placement selects straight from
  // the register, so a change takes effect from the next stop bit on.
  assign tx_double_buffer_mode = serial_port_status_control[`UTIC_BIT_DBUF_MODE];
  assign tx_irq_late_select    = serial_port_status_control[`UTIC_BIT_LATE];

  ////////////////////////////////////////////////////////////////////////////
  // The engine reports stop-bit edges in every mode, but in mode 0 the
  // transmit event comes from the eighth data bit instead, so both stop-bit
  // pulses are masked here.
  utic_tx_sched u_sched (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .dbuf_mode  (tx_double_buffer_mode),
    .dbuf_irq   (serial_port_status_control[`UTIC_BIT_DBUF_IRQ]),
    .late       (tx_irq_late_select),
    .wr_char    (wr_tx),
    .stop_start (stop_start && !mode0),
    .stop_end   (stop_end && !mode0),
    .buf_empty  (buf_empty),
    .tx_event   (tx_event)
  );

  // Mode 0 uses the end of the eighth bit; a late stop point in single
  // buffering may leave the line idle before the next start bit.
  wire tx_set = tx_event || (mode0 && mode0_end);

  ////////////////////////////////////////////////////////////////////////////
  // Done flags: software writes a one in the fault word bit 9/8 to clear.
  // One write may acknowledge both directions at once; a hardware set in the
  // same cycle wins so that a finished character is never missed.
  wire clr_tx_done = wr_flt && w_data[9];
  wire clr_rx_done = wr_flt && w_data[8];

  always @(posedge aclk) begin
    if (!aresetn) begin
      tx_done_flag <= 1'b0;
      rx_done_flag <= 1'b0;
      tx_char      <= 8'h00;
      tx_char_load <= 1'b0;
    end else begin
      tx_done_flag <= tx_set || (tx_done_flag && !clr_tx_done);
      rx_done_flag <= rx_done_set || (rx_done_flag && !clr_rx_done);
      tx_char_load <= wr_tx;
      if (wr_tx)
        tx_char <= w_data[7:0];
    end
  end

  // Fault flags request the shared interrupt only while the status enable is
  // set; with the split bit clear the transmit flag joins the same request.
  wire fault_req = serial_port_status_control[`UTIC_BIT_STAT_EN] &&
                   (|serial_port_status_control[3:1]);
  wire split = serial_port_status_control[`UTIC_BIT_SPLIT];
  assign serial_irq = split ? (rx_done_flag || fault_req) :
                      (rx_done_flag || tx_done_flag || fault_req);
  assign tx_irq = split && tx_done_flag;

  ////////////////////////////////////////////////////////////////////////////
  // Sticky event bits, cleared by reading the status word.
  // A read is accepted only while no answer waits, so at most one read is in
  // flight and rdata never changes under a waiting master.
  assign s_axi_arready = !s_axi_rvalid;
  wire rd_take = s_axi_arvalid && s_axi_arready;
  // Only a read of the status word clears it; any other read leaves it alone.
  wire rd_stat = rd_take && s_axi_araddr == `UTIC_ADDR_IRQ_STATUS;
  wire [`UTIC_EV_COUNT-1:0] ev_set = {framing_set | hold_low_set | overrun_set,
                                      rx_done_set, tx_set};

  // One sticky bit each for transmit, receive and the three faults together. An event that lands in the same cycle
  // as the clearing read stays set, so software never loses it; it is then
  // reported on the following read.
  genvar ev;
  generate
    for (ev = 0; ev < `UTIC_EV_COUNT; ev = ev + 1) begin : g_sticky
      always @(posedge aclk) begin
        if (!aresetn) begin
          irq_status[ev] <= 1'b0;
        end else if (ev_set[ev]) begin
          irq_status[ev] <= 1'b1;
        end else if (rd_stat) begin
          irq_status[ev] <= 1'b0;
        end
      end
    end
  endgenerate

  // The mask has the layout of the status word; a clear bit hides its event
  // from irq but leaves the sticky bit readable.
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask <= {`UTIC_EV_COUNT{1'b0}};
    end else if (wr_mask) begin
      irq_mask <= w_data[`UTIC_EV_COUNT-1:0];
    end
  end

  // Level interrupt: high while any unmasked sticky bit is set.
  assign irq = |(irq_status & irq_mask);

  ////////////////////////////////////////////////////////////////////////////
  // Read data are chosen combinationally and registered on acceptance, so
  // rdata and rresp stand unchanged for as long as rvalid waits for rready.
  reg [31:0] next_rdata;
  reg [1:0]  next_rresp;

  always @* begin
    next_rdata = 32'h00000000;
    next_rresp = `UTIC_RESP_OKAY;
    case (s_axi_araddr)
      `UTIC_ADDR_STATUS_CTRL: begin
        next_rdata = {24'h000000, serial_port_status_control};
      end
      `UTIC_ADDR_IRQ_STATUS: begin
        next_rdata = {29'h00000000, irq_status};
      end
      `UTIC_ADDR_IRQ_MASK: begin
        next_rdata = {29'h00000000, irq_mask};
      end
      `UTIC_ADDR_TX_DATA: begin
        next_rdata = {24'h000000, tx_char};
      end
      `UTIC_ADDR_FAULTS: begin
        next_rdata = {22'h000000, tx_done_flag, rx_done_flag, serial_port_status_control};
      end
      default: begin
        // Unmapped reads answer zero with a slave error.
        next_rresp = `UTIC_RESP_SLVERR;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `UTIC_RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: test/utic_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module utic_checker (
  input wire logic aclk,               // Clock.
  input wire logic aresetn,            // Reset, active low.
  input wire logic stop_start,         // Stop bit begins.
  input wire logic stop_end,           // Stop bit ends.
  input wire logic mode0,              // Mode 0.
  input wire logic mode0_end,          // Eighth bit ends.
  input wire logic tx_irq_late_select, // Late placement.
  input wire logic tx_done_flag,       // Done flag.
  input wire logic serial_irq,         // Shared request.
  input wire logic tx_irq,             // Transmit request.
  input wire logic s_axi_arvalid,      // Read address valid.
  input wire logic s_axi_arready,      // Read address ready.
  input wire logic s_axi_rvalid        // Read valid.
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_early_done: assert property (!mode0 && !tx_irq_late_select && stop_start
    |-> ##2 tx_done_flag) else $error("no done at stop start");
  a_late_done: assert property (!mode0 && tx_irq_late_select && stop_end
    |-> ##2 tx_done_flag) else $error("no done at stop end");
  a_no_early: assert property (!mode0 && tx_irq_late_select && !tx_done_flag
    && stop_start && !stop_end |-> ##2 !tx_done_flag) else $error("done too early");
  a_mode0_done: assert property (mode0 && mode0_end |=> tx_done_flag)
    else $error("no done after eighth bit");
  a_split_req: assert property (tx_irq |-> tx_done_flag)
    else $error("transmit request without done");
  a_combined_req: assert property (tx_done_flag && !tx_irq |-> serial_irq)
    else $error("combined request missing");
  a_reset_clear: assert property ($rose(aresetn) |-> !tx_done_flag && !tx_irq
    && !serial_irq && !tx_irq_late_select) else $error("state after reset");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  c_late: cover property (stop_end && tx_irq_late_select);
  c_split: cover property (tx_irq);
  c_mode0: cover property (mode0 && mode0_end);
endmodule
bind utic_top utic_checker utic_checker_inst (.*);
`default_nettype wire

/* File: test/utic_line_model.sv */
`timescale 1ns/1ps
`default_nettype none
module utic_line_model (
  input  wire logic aclk,         // Clock.
  input  wire logic aresetn,      // Reset, active low.
  input  wire logic tx_char_load, // Character handed over.
  input  wire logic mode0,        // Mode 0.
  output wire logic stop_start,   // Stop bit begins.
  output wire logic stop_end,     // Stop bit ends.
  output wire logic mode0_end,    // Eighth bit ends.
  output wire logic buf_empty     // Nothing pending.
);
  logic [3:0] cnt;
  logic       busy;
  logic       pend;
  // A frame is shortened to twelve cycles; only the stop-bit edges matter here.
  // A character handed over mid-frame waits in pend; buf_empty reports that
  // nothing waits behind the character now on the line.
  always @(posedge aclk) begin
    if (!aresetn) begin
      busy <= 1'b0;
      cnt  <= 4'h0;
      pend <= 1'b0;
    end else if (busy && cnt != 4'hb) begin
      cnt  <= cnt + 4'h1;
      if (tx_char_load) pend <= 1'b1;
    end else begin
      busy <= tx_char_load || pend;
      cnt  <= 4'h0;
      pend <= 1'b0;
    end
  end
  assign stop_start = busy && cnt == 4'h8 && !mode0;
  assign stop_end   = busy && cnt == 4'hb && !mode0;
  assign mode0_end  = busy && cnt == 4'h8 && mode0;
  assign buf_empty  = !pend;
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "utic_regs.vh"
module tb_top;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, mode0 = 0, framing_set = 0;
  logic [9:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [7:0] v;
  logic [31:0] s_axi_wdata = 0;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic tx_char_load, tx_double_buffer_mode, tx_irq_late_select, tx_done_flag;
  wire logic rx_done_flag, serial_irq, tx_irq, irq, stop_start, stop_end, mode0_end, buf_empty;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic [7:0] tx_char;
  wire logic [3:0] s_axi_wstrb = 4'hf;
  wire logic rx_done_set = 1'b0, hold_low_set = 1'b0, overrun_set = 1'b0;
  logic [7:0] cfg [5] = '{8'h00, 8'h40, 8'h20, 8'h80, 8'h90};
  integer n_errors = 0, num_checks = 0;
  utic_top utic_top_inst (.*);
  utic_line_model utic_line_model_inst (.*);
  always #50 aclk = ~aclk;
  //////////////////////////////
  task chk(input [31:0] g, input [31:0] e);
    begin
      num_checks++;
      if (g !== e) begin
        n_errors++;
        $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
    end
  endtask
  // Handshakes are sampled at the rising edge; valid drops right after the
  // edge at which its own ready was seen high.
  task wr(input [9:0] a, input [31:0] d, input [1:0] er);
    logic da, dw;
    begin
      @(posedge aclk);
      s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1;
      s_axi_bready <= 1; da = 0; dw = 0;
      while (!(da && dw)) begin
        @(posedge aclk);
        if (!da && s_axi_awready) begin da = 1; s_axi_awvalid <= 0; end
        if (!dw && s_axi_wready) begin dw = 1; s_axi_wvalid <= 0; end
      end
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      chk(s_axi_bresp, er);
      s_axi_bready <= 0;
    end
  endtask
  task rdc(input [9:0] a, input [31:0] ed, input [1:0] er);
    begin
      @(posedge aclk); s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      chk(s_axi_rdata, ed);
      chk(s_axi_rresp, er);
      s_axi_rready <= 0;
    end
  endtask
  task send;
    begin
      wr(`UTIC_ADDR_TX_DATA, 32'h5a, `UTIC_RESP_OKAY);
      do @(posedge aclk); while (tx_done_flag !== 1'b1);
    end
  endtask
  task end_sim;
    begin
      $display("errors %0d checks %0d", n_errors, num_checks);
      if (n_errors == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  //////////////////////////////
  initial begin
    #2000000;
    n_errors++;
    end_sim;
  end
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    rdc(`UTIC_ADDR_STATUS_CTRL, `UTIC_RESET_STATUS, `UTIC_RESP_OKAY);
    rdc(8'h10, 0, `UTIC_RESP_SLVERR);
    wr(8'h14, 1, `UTIC_RESP_SLVERR);
    wr(`UTIC_ADDR_IRQ_MASK, 7, `UTIC_RESP_OKAY);
    for (int i = 0; i < 5; i++) begin
      v = cfg[i];
      wr(`UTIC_ADDR_STATUS_CTRL, v, `UTIC_RESP_OKAY);
      chk({tx_double_buffer_mode, tx_irq_late_select}, v[7:6]);
      wr(`UTIC_ADDR_TX_DATA, 32'h5a, `UTIC_RESP_OKAY);
      if (v == 8'h90) rdc(`UTIC_ADDR_IRQ_STATUS, 1, `UTIC_RESP_OKAY);
      do @(posedge aclk); while (irq !== 1'b1);
      chk(tx_char, 8'h5a);
      chk({tx_irq, serial_irq, irq}, {v[5], !v[5], 1'b1});
      rdc(`UTIC_ADDR_IRQ_STATUS, 1, `UTIC_RESP_OKAY);
      rdc(`UTIC_ADDR_IRQ_STATUS, 0, `UTIC_RESP_OKAY);
      rdc(`UTIC_ADDR_FAULTS, {22'h0, 2'b10, v}, `UTIC_RESP_OKAY);
      wr(`UTIC_ADDR_FAULTS, 32'h200, `UTIC_RESP_OKAY);
      chk({tx_done_flag, irq}, 0);
    end
    mode0 <= 1;
    wr(`UTIC_ADDR_STATUS_CTRL, 0, `UTIC_RESP_OKAY);
    send;
    rdc(`UTIC_ADDR_IRQ_STATUS, 1, `UTIC_RESP_OKAY);
    wr(`UTIC_ADDR_FAULTS, 32'h200, `UTIC_RESP_OKAY);
    mode0 <= 0;
    wr(`UTIC_ADDR_IRQ_MASK, 0, `UTIC_RESP_OKAY);
    send;
    chk(irq, 0);
    rdc(`UTIC_ADDR_IRQ_STATUS, 1, `UTIC_RESP_OKAY);
    wr(`UTIC_ADDR_FAULTS, 32'h200, `UTIC_RESP_OKAY);
    wr(`UTIC_ADDR_STATUS_CTRL, 8'h21, `UTIC_RESP_OKAY);
    @(posedge aclk); framing_set <= 1;
    @(posedge aclk); framing_set <= 0;
    @(posedge aclk); chk(serial_irq, 1);
    rdc(`UTIC_ADDR_STATUS_CTRL, 8'h29, `UTIC_RESP_OKAY);
    wr(`UTIC_ADDR_STATUS_CTRL, 8'h28, `UTIC_RESP_OKAY);
    chk(serial_irq, 0);
    end_sim;
  end
endmodule
`default_nettype wire
